// ---- hw/smb_ctrl_regs.vh ----
// Constants for the static memory bus controller: address layout and reset levels.
// Assumes a 26-bit byte address from the system bus, top two bits picking the chip select.
`ifndef SMB_CTRL_REGS_VH
`define SMB_CTRL_REGS_VH

// ==========================================
// Address layout
`define SMB_CS_LSB 24
`define SMB_CS_MSB 25
`define SMB_ALE_BIT 21
`define SMB_CLE_BIT 22

// ==========================================
// Reset values
`define SMB_STROBE_IDLE 1'h1
`define SMB_CS_IDLE 4'hF
`define SMB_DATA_RESET 16'h0000
`define SMB_ADDR_RESET 23'h000000

`endif

// ---- hw/smb_ctrl.v ----
// Static memory bus controller: one external access at a time, pin sharing by bus width
// and byte access type, and flash strobe steering per chip select.
// Assumes configuration ports are held stable while an access is in flight.
//
// Overview of operation
// - 16-bit devices leave address bit 0 unused.
// - Shared pins follow width and byte access type.
// - Address bit 1 always leaves on its own pin.
// - Flash strobes only for enabled chip selects.
// - Flash strobes copy read and write strobes.
// - Flash strobes drop when the access leaves.
// - One flash chip select, shared by all chip selects.
// - Byte selects switch together with the address.
// - Byte write strobes share write enable timing.
// - Upper data lanes timed like lower lanes.
// - Each chip select uses its own timings.
// - Address is driven no later than any strobe in each cycle.
// - Read strobe falls after the read setup.
// - Read strobe stays low for the pulse.
// - Address holds for the remaining hold time.
// - Timings are whole clocks; hold is cycle remainder.
// - Read mode picks the data capture edge.
// - Width bit chooses an 8 or 16-bit bus.
`include "smb_ctrl_regs.vh"

module smb_ctrl #(
	parameter N_CS = 4,
	parameter SW = 6,
	parameter PW = 7,
	parameter CW = 9
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	// System side request
	input wire req_valid,
	input wire req_write,
	input wire req_half,
	input wire [25:0] req_addr,
	input wire [15:0] req_wdata,
	// System side answer
	output reg busy,
	output reg resp_valid,
	output reg [15:0] resp_rdata,
	// Per chip select configuration
	input wire [N_CS-1:0] data_bus_width_sel,
	input wire [N_CS-1:0] byte_access_type,
	input wire [N_CS-1:0] read_mode,
	input wire [N_CS-1:0] matrix_flash_cs_config,
	input wire [N_CS*SW-1:0] read_setup_time,
	input wire [N_CS*PW-1:0] read_pulse_time,
	input wire [N_CS*CW-1:0] read_cycle_time,
	input wire [N_CS*SW-1:0] cs_read_setup_time,
	input wire [N_CS*PW-1:0] cs_read_pulse_time,
	input wire [N_CS*SW-1:0] write_setup_time,
	input wire [N_CS*PW-1:0] write_pulse_time,
	input wire [N_CS*CW-1:0] write_cycle_time,
	input wire [N_CS*SW-1:0] cs_write_setup_time,
	input wire [N_CS*PW-1:0] cs_write_pulse_time,
	// Memory pins
	output reg [23:1] addr_out,
	output reg lane0_or_addr0_pin,
	output reg write_or_lowwrite_pin,
	output reg hisel_or_hiwrite_pin,
	output reg read_strobe_n,
	output reg [N_CS-1:0] chip_select_n,
	output reg [15:0] data_out,
	output reg data_oe_n,
	input wire [15:0] data_in,
	// Flash pins
	output reg flash_output_enable_n,
	output reg flash_write_enable_n,
	output reg flash_addr_latch_en,
	output reg flash_cmd_latch_en,
	output reg flash_chip_select_n
);

	// ==========================================
	// Window test shared by every strobe
	function in_win;
		input [CW:0] c;
		input [CW:0] s;
		input [CW:0] l;
		begin
			in_win = (c >= s) && (c < s + l);
		end
	endfunction

	// ==========================================
	// Field helpers
	// Setup field of one chip select, widened to the counter size.
	function [CW:0] pick_setup;
		input [N_CS*SW-1:0] bank;
		input [1:0] idx;
		begin
			pick_setup = {{(CW+1-SW){1'b0}}, bank[idx*SW +: SW]};
		end
	endfunction

	// Pulse field of one chip select, widened to the counter size.
	function [CW:0] pick_pulse;
		input [N_CS*PW-1:0] bank;
		input [1:0] idx;
		begin
			pick_pulse = {{(CW+1-PW){1'b0}}, bank[idx*PW +: PW]};
		end
	endfunction

	// Cycle field of one chip select, one bit wider so the end test cannot wrap.
	function [CW:0] pick_cycle;
		input [N_CS*CW-1:0] bank;
		input [1:0] idx;
		begin
			pick_cycle = {1'b0, bank[idx*CW +: CW]};
		end
	endfunction

	// A byte sent to the upper lane of a wide bus is copied onto both lanes.
	function [15:0] lane_copy;
		input is_wide;
		input is_half;
		input low_bit;
		input [15:0] wd;
		begin
			lane_copy = (is_wide & ~is_half & low_bit) ? {2{wd[7:0]}} : wd;
		end
	endfunction

	// ==========================================
	// Access state
	reg [CW-1:0] cnt;
	reg [1:0] cur_cs;
	reg cur_write;
	reg cur_half;
	reg [25:0] cur_addr;
	reg [15:0] cur_wdata;
	reg [15:0] d1;
	reg [15:0] d2;
	reg [15:0] d3;
	reg [15:0] dfilt;
	reg [CW-1:0] next_cnt;
	reg next_busy;

	wire start = req_valid & ~busy;
	wire [1:0] sel_cs = busy ? cur_cs : req_addr[`SMB_CS_MSB:`SMB_CS_LSB];
	wire sel_write = busy ? cur_write : req_write;
	wire sel_half = busy ? cur_half : req_half;
	wire [25:0] sel_addr = busy ? cur_addr : req_addr;
	wire [15:0] sel_wdata = busy ? cur_wdata : req_wdata;

	// Timing fields of the selected chip select, widened to the counter size.
	wire [CW:0] t_rs = pick_setup(read_setup_time, sel_cs);
	wire [CW:0] t_rp = pick_pulse(read_pulse_time, sel_cs);
	wire [CW:0] t_crs = pick_setup(cs_read_setup_time, sel_cs);
	wire [CW:0] t_crp = pick_pulse(cs_read_pulse_time, sel_cs);
	wire [CW:0] t_ws = pick_setup(write_setup_time, sel_cs);
	wire [CW:0] t_wp = pick_pulse(write_pulse_time, sel_cs);
	wire [CW:0] t_cws = pick_setup(cs_write_setup_time, sel_cs);
	wire [CW:0] t_cwp = pick_pulse(cs_write_pulse_time, sel_cs);
	wire [CW:0] t_cyc = sel_write ? pick_cycle(write_cycle_time, sel_cs) :
		pick_cycle(read_cycle_time, sel_cs);
	wire wide = data_bus_width_sel[sel_cs];
	wire bwrite = byte_access_type[sel_cs];
	wire flash_on = matrix_flash_cs_config[sel_cs];

	// ==========================================
	// Cycle counter
	always @* begin
		next_busy = busy;
		next_cnt = cnt;
		if (busy) begin
			if ({1'b0, cnt} + {{CW{1'b0}}, 1'b1} >= t_cyc) begin
				next_busy = 1'b0;
				next_cnt = {CW{1'b0}};
			end else begin
				next_cnt = cnt + {{(CW-1){1'b0}}, 1'b1};
			end
		end else if (start) begin
			next_busy = 1'b1;
			next_cnt = {CW{1'b0}};
		end
	end

	// ==========================================
	// Next pin levels
	wire [CW:0] nc = {1'b0, next_cnt};
	wire next_rd = next_busy & ~sel_write & in_win(nc, t_rs, t_rp);
	wire next_we = next_busy & sel_write & in_win(nc, t_ws, t_wp);
	wire next_cs = next_busy & (sel_write ? in_win(nc, t_cws, t_cwp) :
		in_win(nc, t_crs, t_crp));
	wire next_drive = next_busy & sel_write & (nc >= t_ws);
	wire a0 = sel_addr[0];
	wire lane0 = ~wide | sel_half | ~a0;
	wire lane1 = wide & (sel_half | a0);
	// Capture happens on the edge that raises the controlling strobe.
	wire rd_rise = ~read_strobe_n & ~next_rd;
	wire cs_rise = ~chip_select_n[cur_cs] & ~next_cs;
	wire capture = busy & ~cur_write & (read_mode[cur_cs] ? rd_rise : cs_rise);

	reg next_p0;
	reg next_p1;
	reg next_p2;
	always @* begin
		if (!wide) begin
			next_p0 = a0;
			next_p1 = ~next_we;
			next_p2 = 1'b1;
		end else if (bwrite) begin
			next_p0 = 1'b1;
			next_p1 = ~(next_we & lane0);
			next_p2 = ~(next_we & lane1);
		end else begin
			next_p0 = ~lane0;
			next_p1 = ~next_we;
			next_p2 = ~lane1;
		end
	end

	// ==========================================
	// Pin input synchroniser
	// The data bus is sampled through three stages, so read data must be steady
	// four clocks before the capture edge; pulses below five clocks read stale data.
	always @(posedge clock) begin
		if (rst) begin
			d1 <= `SMB_DATA_RESET;
			d2 <= `SMB_DATA_RESET;
			d3 <= `SMB_DATA_RESET;
			dfilt <= `SMB_DATA_RESET;
		end else begin
			d1 <= data_in;
			d2 <= d1;
			d3 <= d2;
			if (d2 == d3) begin
				dfilt <= d3;
			end
		end
	end

	// ==========================================
	// Registers
	always @(posedge clock) begin
		if (rst) begin
			busy <= 1'b0;
			cnt <= {CW{1'b0}};
			cur_cs <= 2'h0;
			cur_write <= 1'b0;
			cur_half <= 1'b0;
			cur_addr <= 26'h0000000;
			cur_wdata <= `SMB_DATA_RESET;
			resp_valid <= 1'b0;
			resp_rdata <= `SMB_DATA_RESET;
			addr_out <= `SMB_ADDR_RESET;
			lane0_or_addr0_pin <= `SMB_STROBE_IDLE;
			write_or_lowwrite_pin <= `SMB_STROBE_IDLE;
			hisel_or_hiwrite_pin <= `SMB_STROBE_IDLE;
			read_strobe_n <= `SMB_STROBE_IDLE;
			chip_select_n <= `SMB_CS_IDLE;
			data_out <= `SMB_DATA_RESET;
			data_oe_n <= 1'b1;
			flash_output_enable_n <= `SMB_STROBE_IDLE;
			flash_write_enable_n <= `SMB_STROBE_IDLE;
			flash_addr_latch_en <= 1'b0;
			flash_cmd_latch_en <= 1'b0;
			flash_chip_select_n <= `SMB_STROBE_IDLE;
		end else begin
			busy <= next_busy;
			cnt <= next_cnt;
			resp_valid <= busy & ~next_busy;
			if (start) begin
				cur_cs <= req_addr[`SMB_CS_MSB:`SMB_CS_LSB];
				cur_write <= req_write;
				cur_half <= req_half;
				cur_addr <= req_addr;
				cur_wdata <= req_wdata;
				// Address and byte selects load on the same edge, before any strobe whose setup time is nonzero.
				addr_out <= req_addr[23:1];
				lane0_or_addr0_pin <= next_p0;
				hisel_or_hiwrite_pin <= next_p2;
				data_out <= lane_copy(wide, req_half, a0, req_wdata);
			end else if (busy & sel_write) begin
				hisel_or_hiwrite_pin <= next_p2;
			end
			write_or_lowwrite_pin <= next_p1;
			read_strobe_n <= ~next_rd;
			chip_select_n <= next_cs ? ~(4'h1 << sel_cs) : `SMB_CS_IDLE;
			data_oe_n <= ~next_drive;
			if (capture) begin
				resp_rdata <= dfilt;
			end
			// Flash strobes exist only while an enabled chip select owns the access.
			flash_output_enable_n <= ~(flash_on & next_rd);
			flash_write_enable_n <= ~(flash_on & next_we);
			flash_chip_select_n <= ~(flash_on & next_cs);
			flash_addr_latch_en <= next_busy & flash_on & sel_addr[`SMB_ALE_BIT];
			flash_cmd_latch_en <= next_busy & flash_on & sel_addr[`SMB_CLE_BIT];
		end
	end

	wire unused_wdata = |sel_wdata;

endmodule // smb_ctrl

// ---- tb/smb_ctrl_asserts.sv ----
// Checker for the static memory bus controller.
// Assumes it is bound to smb_ctrl and sees only its ports.
module smb_ctrl_chk #(parameter N_CS = 4, SW = 6, PW = 7, CW = 9) (
	input wire logic clock, rst, req_valid, req_write, busy, resp_valid, read_strobe_n,
	input wire logic [25:0] req_addr,
	input wire logic [23:1] addr_out,
	input wire logic lane0_or_addr0_pin, hisel_or_hiwrite_pin,
	input wire logic [N_CS-1:0] chip_select_n,
	input wire logic flash_output_enable_n, flash_write_enable_n,
	input wire logic [N_CS-1:0] data_bus_width_sel, byte_access_type, matrix_flash_cs_config,
	input wire logic [N_CS*SW-1:0] read_setup_time,
	input wire logic [N_CS*PW-1:0] read_pulse_time,
	input wire logic [N_CS*CW-1:0] read_cycle_time, write_cycle_time
);
	// ==========================================
	// Access tracking
	logic [1:0] cs, a01;
	logic wr;
	logic [9:0] since;
	logic [7:0] lowc;
	wire take = req_valid && !busy;
	wire [CW-1:0] cyc = wr ? write_cycle_time[cs*CW +: CW] : read_cycle_time[cs*CW +: CW];
	wire [9:0] cyc_end = (cyc == 0) ? 10'h002 : 10'(cyc) + 10'h001;
	wire [N_CS-1:0] cs_bit = N_CS'(1) << cs;
	always @(posedge clock) begin
		if (rst) begin
			cs <= 2'h0;
			a01 <= 2'h0;
			wr <= 1'b0;
			since <= 10'h000;
		end else if (take) begin
			cs <= req_addr[25:24];
			a01 <= req_addr[1:0];
			wr <= req_write;
			since <= 10'h001;
		end else begin
			since <= since + 10'h001;
		end
		lowc <= read_strobe_n ? 8'h00 : lowc + 8'h01;
	end
	// ==========================================
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_fall; $fell(read_strobe_n); endsequence
	sequence rd_rise; $rose(read_strobe_n); endsequence
	addr_first_a: assert property (rd_fall |-> $stable(addr_out) && busy)
		else $error("read strobe fell with address moving");
	rd_setup_a: assert property (rd_fall |-> since == 10'(read_setup_time[cs*SW +: SW]) + 10'h001)
		else $error("read setup length wrong");
	rd_pulse_a: assert property (rd_rise |-> lowc == 8'(read_pulse_time[cs*PW +: PW]))
		else $error("read pulse length wrong");
	addr_hold_a: assert property ($changed(addr_out) |-> $past(take))
		else $error("address moved outside a new access");
	cycle_len_a: assert property (resp_valid |-> !busy && since == cyc_end)
		else $error("access cycle length wrong");
	one_cs_a: assert property ((~chip_select_n & ~cs_bit) == '0)
		else $error("wrong chip select asserted");
	pin_share_a: assert property (busy |-> addr_out[1] == a01[1] && (data_bus_width_sel[cs] ?
		(!byte_access_type[cs] || lane0_or_addr0_pin) : (lane0_or_addr0_pin == a01[0] && hisel_or_hiwrite_pin)))
		else $error("shared pin assignment wrong");
	flash_oe_a: assert property (busy |-> flash_output_enable_n == (read_strobe_n || !matrix_flash_cs_config[cs]))
		else $error("flash output enable does not follow read strobe");
	flash_off_a: assert property (!busy |-> flash_output_enable_n && flash_write_enable_n)
		else $error("flash strobe active outside an access");
endmodule // smb_ctrl_chk

// ---- tb/smb_mem_model.sv ----
// Behavioural external memory on the far side of the controller.
// Assumes a word reads back as a fixed function of its address.
module smb_mem_model (
	input wire logic clock,
	input wire logic [23:1] addr_out,
	input wire logic [3:0] chip_select_n,
	input wire logic data_oe_n,
	input wire logic host_ce_n,
	output logic [15:0] data_in
);
	logic [15:0] idle_pat = 16'h0000;
	always @(posedge clock) idle_pat <= idle_pat + 16'h3C5B;
	// A released bus floats, so a moving pattern stands in for its level.
	// The device only answers while the host keeps its own enable line low.
	assign data_in = (&chip_select_n || !data_oe_n || host_ce_n) ? idle_pat :
		{addr_out[8:1] ^ 8'h5A, addr_out[16:9]};
endmodule // smb_mem_model

// ---- tb/smb_ctrl_test.sv ----
// Self-checking bench for the static memory bus controller.
// Assumes a 50 MHz clock and the behavioural memory on the pins.
module smb_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam N_CS = 4, SW = 6, PW = 7, CW = 9;
	logic clock, rst, req_valid, req_write, req_half, resp_valid, busy, data_oe_n, read_strobe_n;
	logic [25:0] req_addr;
	logic [15:0] req_wdata, resp_rdata, data_out, data_in, lf;
	logic [3:0] data_bus_width_sel, byte_access_type, read_mode, matrix_flash_cs_config, chip_select_n;
	logic [23:0] read_setup_time, cs_read_setup_time, write_setup_time, cs_write_setup_time;
	logic [27:0] read_pulse_time, cs_read_pulse_time, write_pulse_time, cs_write_pulse_time;
	logic [35:0] read_cycle_time, write_cycle_time;
	logic [23:1] addr_out;
	logic lane0_or_addr0_pin, write_or_lowwrite_pin, hisel_or_hiwrite_pin;
	logic flash_output_enable_n, flash_write_enable_n, flash_addr_latch_en, flash_cmd_latch_en;
	logic flash_chip_select_n, host_ce_n;
	int n_fail = 0, num_checks = 0;
	smb_ctrl i_dut (.*);
	smb_mem_model i_mem (.clock(clock), .addr_out(addr_out), .chip_select_n(chip_select_n),
		.data_oe_n(data_oe_n), .host_ce_n(host_ce_n), .data_in(data_in));
	function automatic logic [15:0] nx(input logic [15:0] v);
		nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Pulses stay at least one clock; read pulses stay at least four, while the input filter needs five.
	task automatic cfg(input int t);
		logic [5:0] s;
		logic [6:0] p;
		logic [8:0] c;
		for (int i = 0; i < 4; i++) begin
			lf = nx(lf);
			s = 6'(lf[1:0] % 3 + 1);
			p = 7'(lf[3:2] + 4);
			c = 9'(s + p + ((t < 4) ? 0 : lf[5:4]));
			read_setup_time[i*6 +: 6] <= s;
			write_setup_time[i*6 +: 6] <= s;
			read_pulse_time[i*7 +: 7] <= p;
			write_pulse_time[i*7 +: 7] <= p - 7'h03;
			cs_read_pulse_time[i*7 +: 7] <= 7'(c);
			cs_write_pulse_time[i*7 +: 7] <= 7'(c);
			read_cycle_time[i*9 +: 9] <= c;
			write_cycle_time[i*9 +: 9] <= c;
		end
		{data_bus_width_sel, byte_access_type, read_mode, matrix_flash_cs_config} <= nx(lf);
	endtask
	task automatic access(input logic [25:0] a, input logic w);
		logic oe, ale, cle, fwe, fcs, wlo, drv, wd, bw, fl, ln0;
		logic [3:0] csl;
		logic [15:0] dseen, wdat;
		{oe, ale, cle, fwe, fcs, wlo, drv} = '0;
		csl = 4'h0;
		dseen = 16'h0000;
		wdat = lf;
		wd = data_bus_width_sel[a[25:24]];
		bw = byte_access_type[a[25:24]];
		fl = matrix_flash_cs_config[a[25:24]];
		req_valid <= 1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= wdat;
		@(posedge clock);
		req_valid <= 0;
		for (int k = 0; k < 600 && resp_valid !== 1'b1; k++) begin
			@(posedge clock);
			#1;
			oe |= !flash_output_enable_n;
			fwe |= !flash_write_enable_n;
			fcs |= !flash_chip_select_n;
			ale |= flash_addr_latch_en;
			cle |= flash_cmd_latch_en;
			wlo |= !write_or_lowwrite_pin;
			csl |= ~chip_select_n;
			if (!data_oe_n) begin
				drv = 1;
				dseen = data_out;
			end
		end
		ln0 = !wd || req_half || !a[0];
		if (resp_valid !== 1'b1) chk("resp_valid", 16'h0001, 16'h0000);
		if (!w) chk("resp_rdata", {a[8:1] ^ 8'h5A, a[16:9]}, resp_rdata);
		chk("flash oe", 16'(!w && fl), 16'(oe));
		chk("flash we", 16'(w && fl), 16'(fwe));
		chk("flash cs", 16'(fl), 16'(fcs));
		chk("flash ale", 16'(fl && a[21]), 16'(ale));
		chk("flash cle", 16'(fl && a[22]), 16'(cle));
		chk("chip select", 16'(4'h1 << a[25:24]), 16'(csl));
		chk("low write", 16'(w && (!wd || !bw || ln0)), 16'(wlo));
		chk("write pin idle", 16'h0001, 16'(write_or_lowwrite_pin));
		chk("data drive", 16'(w), 16'(drv));
		if (w) chk("data_out", (wd && !req_half && a[0]) ? {2{wdat[7:0]}} : wdat, dseen);
	endtask
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		give_verdict;
	end
	initial begin
		{rst, req_valid, req_write, req_half, req_addr, req_wdata} = 46'h200000000000;
		{data_bus_width_sel, byte_access_type, read_mode, matrix_flash_cs_config} = 16'h0000;
		{read_setup_time, cs_read_setup_time, write_setup_time, cs_write_setup_time} = '0;
		{read_pulse_time, cs_read_pulse_time, write_pulse_time, cs_write_pulse_time} = '0;
		{read_cycle_time, write_cycle_time} = '0;
		lf = 16'h001F;
		host_ce_n = 1;
		repeat (4) @(posedge clock);
		rst <= 0;
		host_ce_n <= 0;
		for (int t = 0; t < 48; t++) begin
			@(posedge clock);
			cfg(t);
			@(posedge clock);
			lf = nx(lf);
			req_half <= lf[5];
			access({lf[1:0], 1'b0, lf[3:2], 5'h00, lf}, lf[4]);
			$display("test %0d done", t);
		end
		give_verdict;
	end
endmodule // smb_ctrl_test
bind smb_ctrl smb_ctrl_chk #(.N_CS(N_CS), .SW(SW), .PW(PW), .CW(CW)) i_chk (.*);
